// [rtl/fbc_pkg.sv]
/*
 * fbc_pkg: constants and types shared by the flash bus command host.
 * Assumes a 25 MHz ref_clk; all pin timings are derived from it here.
 */
package fbc_pkg;

    localparam int CLK_PERIOD_NS = 40;

    // pin-level timings in ns, rounded up to whole clock cycles
    localparam int T_SETUP_NS   = 40;
    localparam int T_WE_LOW_NS  = 70;
    localparam int T_HOLD_NS    = 40;
    localparam int T_ACCESS_NS  = 150;
    localparam int T_RST_LOW_NS = 25000;
    localparam int T_WAKE_NS    = 1000;

    localparam int SETUP_CYC   =
        (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WE_LOW_CYC  =
        (T_WE_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HOLD_CYC    =
        (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int ACCESS_CYC  =
        (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_LOW_CYC =
        (T_RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYC    =
        (T_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    localparam int CNT_W  = 10;
    localparam int ADDR_W = 23;
    localparam int DATA_W = 16;

    localparam logic [2:0]        CS_ENABLE   = 3'h0;
    localparam logic [2:0]        CS_DISABLE  = 3'h7;
    localparam logic [DATA_W-1:0] BUSY_MASK   = 16'h0080;
    localparam logic [DATA_W-1:0] BYTE_MASK   = 16'h00ff;
    localparam logic [DATA_W-1:0] DATA_RESET  = 16'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET  = 23'h00_0000;

    typedef enum logic [1:0] {
        FBC_OP_READ,
        FBC_OP_WRITE,
        FBC_OP_RESET,
        FBC_OP_NONE
    } fbc_op_t;

endpackage

// [rtl/fbc_sync.sv]
/*
 * fbc_sync: two-flop synchroniser for pin inputs.
 * Assumes inputs are asynchronous levels; output is two clocks late.
 */
`timescale 1ns/1ps
`default_nettype none
module fbc_sync #(
    parameter int          W         = 1,
    parameter logic [W-1:0] RESET_VAL = '0
) (
    input  wire logic         ref_clk,
    input  wire logic         srst,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] meta_next;
    logic [W-1:0] sync_reg;
    logic [W-1:0] sync_next;

    always_comb begin
        meta_next = async_in;
        sync_next = meta_reg;
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            meta_reg <= RESET_VAL;
            sync_reg <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_out = sync_reg;
endmodule
`default_nettype wire

// [rtl/fbc_host.sv]
/*
 * fbc_host: host-side controller driving a parallel NOR flash bus.
 * Performs single read, command write and reset-pulse cycles on request.
 * Assumes the caller supplies command codes and addresses; the data bus
 * is resolved outside from dq_out and dq_oe, busy line is pulled up.
 */
`timescale 1ns/1ps
`default_nettype none
module fbc_host
    import fbc_pkg::*;
(
    input  wire logic                       ref_clk,
    input  wire logic                       srst,
    input  wire logic                       req_valid,
    input  wire fbc_pkg::fbc_op_t           req_op,
    input  wire logic [fbc_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [fbc_pkg::DATA_W-1:0] req_wdata,
    input  wire logic                       word_mode,
    input  wire logic                       prog_enable,
    output logic                            req_ready,
    output logic                            resp_valid,
    output logic      [fbc_pkg::DATA_W-1:0] resp_rdata,
    output logic                            engine_busy,
    output logic      [2:0]                 chip_select_lines,
    output logic                            oe_n,
    output logic                            we_n,
    output logic                            reset_powerdown_n,
    output logic      [fbc_pkg::ADDR_W-1:0] addr_out,
    output logic      [fbc_pkg::DATA_W-1:0] dq_out,
    output logic      [1:0]                 dq_oe,
    input  wire logic [fbc_pkg::DATA_W-1:0] dq_in,
    output logic                            bus_width_sel,
    output logic                            program_enable_voltage_pin,
    input  wire logic                       busy_flag_out
);
    import fbc_pkg::*;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SETUP,
        ST_WE_LOW,
        ST_HOLD,
        ST_READ,
        ST_RST_LOW,
        ST_WAKE
    } fbc_state_t;

    fbc_state_t          state_reg,  state_next;
    fbc_op_t             op_reg,     op_next;
    logic [CNT_W-1:0]    cnt_reg,    cnt_next;
    logic                ready_reg,  ready_next;
    logic                rvalid_reg, rvalid_next;
    logic [DATA_W-1:0]   rdata_reg,  rdata_next;
    logic [2:0]          cs_reg,     cs_next;
    logic                oe_n_reg,   oe_n_next;
    logic                we_n_reg,   we_n_next;
    logic                pd_n_reg,   pd_n_next;
    logic [ADDR_W-1:0]   addr_reg,   addr_next;
    logic [DATA_W-1:0]   dqo_reg,    dqo_next;
    logic [1:0]          dqoe_reg,   dqoe_next;
    logic                width_reg,  width_next;
    logic                pgen_reg,   pgen_next;
    logic                busy_reg,   busy_next;
    logic [DATA_W-1:0]   dq_sync;
    logic                busy_pin_sync;

    // data pins are asynchronous to ref_clk during reads
    fbc_sync #(.W(DATA_W), .RESET_VAL(DATA_RESET)) u_dq_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in (dq_in),
        .sync_out (dq_sync)
    );

    // busy line idles high through the pull-up
    fbc_sync #(.W(1), .RESET_VAL(1'b1)) u_busy_sync (
        .ref_clk  (ref_clk),
        .srst     (srst),
        .async_in (busy_flag_out),
        .sync_out (busy_pin_sync)
    );

    always_comb begin
        state_next  = state_reg;
        op_next     = op_reg;
        cnt_next    = cnt_reg;
        ready_next  = ready_reg;
        rvalid_next = 1'b0;
        rdata_next  = rdata_reg;
        cs_next     = cs_reg;
        oe_n_next   = oe_n_reg;
        we_n_next   = we_n_reg;
        pd_n_next   = pd_n_reg;
        addr_next   = addr_reg;
        dqo_next    = dqo_reg;
        dqoe_next   = dqoe_reg;
        width_next  = width_reg;
        pgen_next   = prog_enable;
        busy_next   = ~busy_pin_sync;
        case (state_reg)
            ST_IDLE: begin
                if (req_valid && ready_reg && req_op != FBC_OP_NONE) begin
                    ready_next = 1'b0;
                    op_next    = req_op;
                    width_next = word_mode;
                    if (req_op == FBC_OP_RESET) begin
                        pd_n_next  = 1'b0;
                        cnt_next   = CNT_W'(RST_LOW_CYC);
                        state_next = ST_RST_LOW;
                    end else begin
                        addr_next  = req_addr;
                        dqo_next   = req_wdata;
                        cs_next    = CS_ENABLE;
                        cnt_next   = CNT_W'(SETUP_CYC);
                        state_next = ST_SETUP;
                    end
                end
            end
            ST_SETUP: begin
                if (cnt_reg > CNT_W'(1)) begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end else if (op_reg == FBC_OP_WRITE) begin
                    oe_n_next  = 1'b1;
                    we_n_next  = 1'b0;
                    dqoe_next  = {width_reg, 1'b1};
                    cnt_next   = CNT_W'(WE_LOW_CYC);
                    state_next = ST_WE_LOW;
                end else begin
                    we_n_next  = 1'b1;
                    oe_n_next  = 1'b0;
                    cnt_next   = CNT_W'(ACCESS_CYC + 2);
                    state_next = ST_READ;
                end
            end
            ST_WE_LOW: begin
                if (cnt_reg > CNT_W'(1)) begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end else begin
                    we_n_next  = 1'b1;
                    cnt_next   = CNT_W'(HOLD_CYC);
                    state_next = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (cnt_reg > CNT_W'(1)) begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end else begin
                    cs_next     = CS_DISABLE;
                    dqoe_next   = 2'h0;
                    ready_next  = 1'b1;
                    rvalid_next = 1'b1;
                    state_next  = ST_IDLE;
                end
            end
            ST_READ: begin
                // two extra cycles cover the data synchroniser delay
                if (cnt_reg > CNT_W'(1)) begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end else begin
                    rdata_next = dq_sync;
                    // only bit seven valid while busy
                    if (busy_reg) begin
                        rdata_next = dq_sync & BUSY_MASK;
                    end else if (!width_reg) begin
                        rdata_next = dq_sync & BYTE_MASK;
                    end
                    oe_n_next   = 1'b1;
                    cs_next     = CS_DISABLE;
                    ready_next  = 1'b1;
                    rvalid_next = 1'b1;
                    state_next  = ST_IDLE;
                end
            end
            ST_RST_LOW: begin
                if (cnt_reg > CNT_W'(1)) begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end else begin
                    pd_n_next  = 1'b1;
                    cnt_next   = CNT_W'(WAKE_CYC);
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                // no bus cycle until the device has woken
                if (cnt_reg > CNT_W'(1)) begin
                    cnt_next = cnt_reg - CNT_W'(1);
                end else begin
                    ready_next  = 1'b1;
                    rvalid_next = 1'b1;
                    state_next  = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                ready_next = 1'b1;
            end
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state_reg  <= ST_IDLE;
            op_reg     <= FBC_OP_NONE;
            cnt_reg    <= '0;
            ready_reg  <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg  <= DATA_RESET;
            cs_reg     <= CS_DISABLE;
            oe_n_reg   <= 1'b1;
            we_n_reg   <= 1'b1;
            pd_n_reg   <= 1'b1;
            addr_reg   <= ADDR_RESET;
            dqo_reg    <= DATA_RESET;
            dqoe_reg   <= 2'h0;
            width_reg  <= 1'b1;
            pgen_reg   <= 1'b0;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            op_reg     <= op_next;
            cnt_reg    <= cnt_next;
            ready_reg  <= ready_next;
            rvalid_reg <= rvalid_next;
            rdata_reg  <= rdata_next;
            cs_reg     <= cs_next;
            oe_n_reg   <= oe_n_next;
            we_n_reg   <= we_n_next;
            pd_n_reg   <= pd_n_next;
            addr_reg   <= addr_next;
            dqo_reg    <= dqo_next;
            dqoe_reg   <= dqoe_next;
            width_reg  <= width_next;
            pgen_reg   <= pgen_next;
            busy_reg   <= busy_next;
        end
    end

    assign req_ready                  = ready_reg;
    assign resp_valid                 = rvalid_reg;
    assign resp_rdata                 = rdata_reg;
    assign engine_busy                = busy_reg;
    assign chip_select_lines          = cs_reg;
    assign oe_n                       = oe_n_reg;
    assign we_n                       = we_n_reg;
    assign reset_powerdown_n          = pd_n_reg;
    assign addr_out                   = addr_reg;
    assign dq_out                     = dqo_reg;
    assign dq_oe                      = dqoe_reg;
    assign bus_width_sel              = width_reg;
    assign program_enable_voltage_pin = pgen_reg;
endmodule
`default_nettype wire

// [testbench/fbc_host_monitor.sv]
/* fbc_host_monitor: pin and handshake checks on the flash bus host.
   assumes one ref_clk domain; bound to every fbc_host instance. */
`timescale 1ns/1ps
`default_nettype none
module fbc_host_monitor (
    input wire logic                       ref_clk,
    input wire logic                       srst,
    input wire logic                       req_valid,
    input wire fbc_pkg::fbc_op_t           req_op,
    input wire logic                       req_ready,
    input wire logic                       resp_valid,
    input wire logic                       prog_enable,
    input wire logic                       engine_busy,
    input wire logic [2:0]                 chip_select_lines,
    input wire logic                       oe_n,
    input wire logic                       we_n,
    input wire logic [fbc_pkg::ADDR_W-1:0] addr_out,
    input wire logic [fbc_pkg::DATA_W-1:0] dq_out,
    input wire logic [1:0]                 dq_oe,
    input wire logic                       bus_width_sel,
    input wire logic                       program_enable_voltage_pin,
    input wire logic                       busy_flag_out
);
    import fbc_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic acc_wr, acc_rd, cs_on;
    assign acc_wr = req_valid && req_ready && req_op == FBC_OP_WRITE;
    assign acc_rd = req_valid && req_ready && req_op == FBC_OP_READ;
    assign cs_on = chip_select_lines == CS_ENABLE;
    sequence s_wr;
        ##1 cs_on ##1 !we_n [*2] ##1 (we_n && cs_on) ##1 resp_valid;
    endsequence
    sequence s_rd;
        ##1 cs_on ##1 (!oe_n && we_n) [*6] ##1 (oe_n && resp_valid);
    endsequence
    a_strobes_exclusive: assert property (oe_n || we_n)
        else $error("oe_n and we_n low together");
    a_write_selected: assert property (!we_n |-> cs_on && dq_oe[0])
        else $error("write strobe without select or data");
    a_write_walk: assert property (acc_wr |-> s_wr)
        else $error("write cycle shape wrong");
    a_read_walk: assert property (acc_rd |-> s_rd)
        else $error("read cycle shape wrong");
    a_upper_lanes: assert property (dq_oe[1] |-> bus_width_sel)
        else $error("upper lanes driven in byte mode");
    a_addr_held: assert property ((!we_n || $rose(we_n)) |->
        $stable(addr_out) && $stable(dq_out))
        else $error("address or data moved under strobe");
    a_busy_follow: assert property (!$past(srst, 3) |->
        engine_busy == !$past(busy_flag_out, 3))
        else $error("busy flag does not follow pin");
    a_enable_pin: assert property (!$past(srst) |->
        program_enable_voltage_pin == $past(prog_enable))
        else $error("program enable pin wrong");
endmodule
bind fbc_host fbc_host_monitor u_mon (.ref_clk, .srst, .req_valid, .req_op,
    .req_ready, .resp_valid, .prog_enable, .engine_busy, .chip_select_lines,
    .oe_n, .we_n, .addr_out, .dq_out, .dq_oe, .bus_width_sel,
    .program_enable_voltage_pin, .busy_flag_out);
`default_nettype wire

// [testbench/fbc_flash_model.sv]
/* fbc_flash_model: behavioural flash device on the far side of the host.
   assumes the bench resolves dq from both enables and pulls busy up. */
`timescale 1ns/1ps
`default_nettype none
module fbc_flash_model #(
    parameter logic [15:0] ID_MAKER = 16'h5a3c, // arbitrary value
    parameter logic [15:0] ID_PART  = 16'h0c71, // arbitrary value
    // off the clock grid so the busy edge never races a sampling edge
    parameter int          BUSY_NS  = 4010
) (
    input  wire logic [2:0]  chip_select_lines,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        reset_powerdown_n,
    input  wire logic [22:0] addr,
    input  wire logic [15:0] dq,
    input  wire logic        bus_width_sel,
    input  wire logic        program_enable_voltage_pin,
    output logic      [15:0] m_dq,
    output logic      [15:0] m_en,
    output logic             busy_low
);
    import fbc_pkg::*;
    logic [7:0]  pend = 8'h00;
    logic [63:0] lock = '0;
    logic [22:0] prog_addr = '0;
    logic        idm = 1'b0;
    logic        busy = 1'b0;
    logic        armed = 1'b0;
    logic        sel, wr, rd_on;
    logic [15:0] id;
    assign sel = chip_select_lines[2] ? chip_select_lines[1:0] != 2'b11
                                      : chip_select_lines[1:0] == 2'b00;
    assign wr = sel && !we_n && reset_powerdown_n;
    assign rd_on = sel && !oe_n && we_n && reset_powerdown_n;
    always_comb begin
        case (addr[1:0])
            2'd0: id = ID_MAKER;
            2'd1: id = ID_PART;
            2'd2: id = {15'h0000, lock[addr[22:17]]};
            default: id = 16'h0000;
        endcase
    end
    assign m_en = !rd_on ? 16'h0000 : busy ? BUSY_MASK :
                  bus_width_sel ? 16'hffff : BYTE_MASK;
    assign m_dq = busy ? 16'h0000 : idm ? id : ~addr[15:0];
    assign busy_low = busy;
    // a start-up x to 0 edge on wr must not look like a write
    always @(posedge wr) armed = 1'b1;
    // latch at strobe or select end
    always @(negedge wr) begin
        if (armed && reset_powerdown_n) begin
            if (pend != 8'h00) begin
                if (program_enable_voltage_pin) begin
                    if (pend == 8'h60) lock[addr[22:17]] = 1'b1;
                    else prog_addr = addr;
                    busy = 1'b1;
                    fork
                        #(BUSY_NS) busy = 1'b0;
                    join_none
                end
                pend = 8'h00;
            end else if (dq[7:0] == 8'h90) idm = 1'b1;
            else if (dq[7:0] == 8'hff) idm = 1'b0;
            else pend = dq[7:0];
        end
        armed = 1'b0;
    end
    always @(negedge reset_powerdown_n) begin
        busy = 1'b0;
        idm = 1'b0;
        pend = 8'h00;
    end
endmodule
`default_nettype wire

// [testbench/tb.sv]
/* tb: self-checking bench for fbc_host against the flash model.
   assumes fbc_pkg timings; undriven dq lines toggle every cycle. */
`timescale 1ns/1ps
`default_nettype none
module tb;
    import fbc_pkg::*;
    localparam logic [15:0] MAKER = 16'h5a3c; // arbitrary value
    localparam logic [15:0] PART  = 16'h0c71; // arbitrary value
    logic ref_clk = 1'b0, srst = 1'b1, req_valid = 1'b0;
    logic word_mode = 1'b1, prog_enable = 1'b0;
    fbc_op_t req_op = FBC_OP_NONE;
    logic [ADDR_W-1:0] req_addr = '0, addr_out;
    logic [DATA_W-1:0] req_wdata = '0, resp_rdata, dq_out, m_dq, m_en;
    logic [DATA_W-1:0] h_en, junk = 16'ha5c3;
    logic req_ready, resp_valid, engine_busy, oe_n, we_n, busy_low;
    logic reset_powerdown_n, bus_width_sel, program_enable_voltage_pin;
    logic [2:0] chip_select_lines;
    logic [1:0] dq_oe;
    wire logic [DATA_W-1:0] dq;
    wire logic busy_pin;
    int fails = 0, comparisons = 0, n, p;
    initial forever #(CLK_PERIOD_NS / 2) ref_clk = ~ref_clk;
    always @(posedge ref_clk) junk <= ~junk;
    assign h_en = {{8{dq_oe[1]}}, {8{dq_oe[0]}}};
    assign dq = (h_en & dq_out) | (~h_en & m_en & m_dq)
              | (~h_en & ~m_en & junk);
    assign busy_pin = !busy_low;
    fbc_host dut (.ref_clk, .srst, .req_valid, .req_op, .req_addr, .req_wdata,
        .word_mode, .prog_enable, .req_ready, .resp_valid, .resp_rdata,
        .engine_busy, .chip_select_lines, .oe_n, .we_n, .reset_powerdown_n,
        .addr_out, .dq_out, .dq_oe, .dq_in(dq), .bus_width_sel,
        .program_enable_voltage_pin, .busy_flag_out(busy_pin));
    fbc_flash_model #(.ID_MAKER(MAKER), .ID_PART(PART)) u_flash (
        .chip_select_lines, .oe_n, .we_n, .reset_powerdown_n, .addr(addr_out),
        .dq, .bus_width_sel, .program_enable_voltage_pin, .m_dq, .m_en,
        .busy_low);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t %s: %h expected %h", $time, what, seen, exp);
        end
    endtask
    task automatic op(input fbc_op_t o, input logic [22:0] a,
                      input logic [15:0] d);
        req_op <= o;
        req_addr <= a;
        req_wdata <= d;
        req_valid <= 1'b1;
        do @(posedge ref_clk); while (req_ready !== 1'b1);
        req_valid <= 1'b0;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (resp_valid !== 1'b1 && n < 900);
        chk(resp_valid, 1'b1, "response");
    endtask
    task automatic wait_busy(input logic lvl);
        int i;
        for (i = 0; i < 300 && engine_busy !== lvl; i++) @(posedge ref_clk);
        chk(engine_busy, lvl, "busy level");
    endtask
    task automatic t_reset;
        chk(chip_select_lines, CS_DISABLE, "select idle");
        chk({oe_n, we_n, reset_powerdown_n, dq_oe}, 5'h1c, "strobes");
        op(FBC_OP_RESET, '0, '0);
        chk(n, 1 + RST_LOW_CYC + WAKE_CYC, "reset length");
        $display("t_reset done");
    endtask
    task automatic t_id;
        op(FBC_OP_READ, 23'h00_1234, '0);
        chk(resp_rdata, 16'hedcb, "array read");
        op(FBC_OP_WRITE, 23'h7f_ff00, 16'h0090);
        chk(n, 1 + SETUP_CYC + WE_LOW_CYC + HOLD_CYC, "write length");
        op(FBC_OP_READ, 23'h00_0000, '0);
        chk(resp_rdata, MAKER, "maker code");
        op(FBC_OP_READ, 23'h00_0001, '0);
        chk(resp_rdata, PART, "part code");
        $display("t_id done");
    endtask
    task automatic t_byte;
        word_mode <= 1'b0;
        op(FBC_OP_READ, 23'h00_0000, '0);
        chk(resp_rdata, MAKER & BYTE_MASK, "byte read");
        chk(bus_width_sel, 1'b0, "width pin");
        // byte-mode write: upper lanes must stay released
        op(FBC_OP_WRITE, 23'h00_0000, 16'hff90);
        chk(n, 1 + SETUP_CYC + WE_LOW_CYC + HOLD_CYC, "byte write");
        word_mode <= 1'b1;
        $display("t_byte done");
    endtask
    task automatic t_lock;
        for (p = 0; p < 2; p++) begin
            prog_enable <= p[0];
            op(FBC_OP_WRITE, 23'h06_0000, 16'h0060);
            op(FBC_OP_WRITE, 23'h06_1234, 16'h0001);
            if (p == 1) wait_busy(1'b1);
            wait_busy(1'b0);
            op(FBC_OP_WRITE, 23'h00_0000, 16'h0090);
            op(FBC_OP_READ, 23'h06_0002, '0);
            chk(resp_rdata, p, "block lock code");
            op(FBC_OP_READ, 23'h04_0002, '0);
            chk(resp_rdata, 16'h0000, "other block code");
        end
        $display("t_lock done");
    endtask
    task automatic t_busy;
        op(FBC_OP_WRITE, 23'h00_0000, 16'h0040);
        op(FBC_OP_WRITE, 23'h12_3456, 16'hbeef);
        chk(u_flash.prog_addr, 23'h12_3456, "program address");
        wait_busy(1'b1);
        op(FBC_OP_READ, 23'h00_0000, '0);
        chk(resp_rdata, 16'h0000, "busy status read");
        wait_busy(1'b0);
        op(FBC_OP_WRITE, 23'h00_0000, 16'h0020);
        op(FBC_OP_WRITE, 23'h0a_1000, 16'h00d0);
        chk(u_flash.prog_addr[22:17], 6'h05, "erase block");
        wait_busy(1'b1);
        wait_busy(1'b0);
        $display("t_busy done");
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        #(CLK_PERIOD_NS * 20000);
        fails++;
        stop_test();
    end
    initial begin
        repeat (12) @(posedge ref_clk);
        srst <= 1'b0;
        t_reset();
        t_id();
        t_byte();
        t_lock();
        t_busy();
        stop_test();
    end
endmodule
`default_nettype wire
